//--- rtl/sbc_defines.svh
// Purpose: timing counts, reset values and field constants for the switch blind control
// Assumes: 25 MHz system clock
// Notes:   times are kept in their own unit; cycle counts are derived from them
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

`define SBC_CLK_HZ          25000000
`define SBC_TICK_MS         1
`define SBC_MS_CYCLES       (`SBC_CLK_HZ / 1000 * `SBC_TICK_MS)
`define SBC_SEC_MS          1000
`define SBC_SHORT_MS        350
`define SBC_HOLD_MS         2000
`define SBC_DEADTIME_MS     20
`define SBC_SLAT_TRAVEL_RST 16'h03E8
`define SBC_SLAT_STEPS_RST  8'h0A
`define SBC_OVERRUN_DIV     20
`define SBC_POS_FULL        7'h64
`define SBC_POS_EMPTY       7'h00
`define SBC_CONTACT_NC      1'b0

`endif

//--- rtl/sbc_pkg.sv
// Purpose: shared types of the switch blind control
// Assumes: nothing
// Notes:   one-hot codes are written out
package sbc_pkg;
	typedef enum logic [3:0] {
		SBC_IDLE = 4'h1,
		SBC_GAP  = 4'h2,
		SBC_RUN  = 4'h4,
		SBC_HOLD = 4'h8
	} sbc_state_e;

	typedef enum logic [4:0] {
		SBC_K_STEP  = 5'h01,
		SBC_K_BSTEP = 5'h02,
		SBC_K_FULL  = 5'h04,
		SBC_K_OVR   = 5'h08,
		SBC_K_REST  = 5'h10
	} sbc_kind_e;
endpackage

//--- rtl/sbc_top.sv
// Purpose: switch and motion driven light relays plus time based blind and slat control
// Assumes: one 25 MHz clock, synchronous active-low reset, raw pins on all switch inputs
// Notes:   blind and slat positions are tracked by running time only, no sensor feedback
`timescale 1ns/1ps
`include "sbc_defines.svh"

module sbc_top
#(
	parameter int MS_CYCLES = `SBC_MS_CYCLES
)
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        switch_input_one,
	input  wire logic        switch_input_two,
	input  wire logic        sensor_input_one,
	input  wire logic        sensor_input_two,
	input  wire logic        raise_switch_input,
	input  wire logic        lower_switch_input,
	input  wire logic [1:0]  sensor_polarity_select,
	input  wire logic [1:0]  motion_block_bit,
	input  wire logic [15:0] motion_off_delay,
	input  wire logic        group_sensor_en,
	input  wire logic        group_sensor_src,
	input  wire logic        group_switch_en,
	input  wire logic        group_switch_src,
	input  wire logic        slat_cfg_wr,
	input  wire logic [7:0]  slat_step_count_wr,
	input  wire logic [15:0] slat_travel_ms_wr,
	input  wire logic [19:0] blind_up_time_ms,
	input  wire logic [19:0] blind_down_time_ms,
	output logic             light_relay_one,
	output logic             light_relay_two,
	output logic [1:0]       light_on_state_flag,
	output logic             group_on_state_flag,
	output logic             raise_motor_output,
	output logic             lower_motor_output,
	output logic             blind_moving,
	output logic [6:0]       blind_position,
	output logic [7:0]       slat_position,
	output logic [7:0]       slat_step_count,
	output logic [15:0]      slat_travel_ms
);
	import sbc_pkg::*;

	localparam int NPIN = 6;

	// percentage of travel covered by ms of running against a full travel time
	function automatic logic [6:0] sbc_pct(input logic [19:0] ms, input logic [19:0] full);
		logic [26:0] prod;
		logic [26:0] quo;
		prod = 27'(ms) * 27'd100;
		quo  = (full == 20'h00000) ? 27'h0000000 : prod / 27'(full);
		sbc_pct = (quo > 27'd100) ? `SBC_POS_FULL : quo[6:0];
	endfunction

	// pin synchronisers: three flops, a change counts once stages two and three agree
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sy1_q;
	logic [NPIN-1:0] sy2_q;
	logic [NPIN-1:0] sy3_q;
	logic [NPIN-1:0] pin_q;
	logic [NPIN-1:0] pin_prev_q;
	logic [NPIN-1:0] rise;
	logic [NPIN-1:0] fall;

	assign pin_raw = {lower_switch_input, raise_switch_input, sensor_input_two,
		sensor_input_one, switch_input_two, switch_input_one};

	genvar gp;
	generate
		for (gp = 0; gp < NPIN; gp++)
		begin : g_sync
			logic idle;

			// sensors start at their no-motion level, else reset itself looks like motion
			assign idle = (gp == 2 || gp == 3) ? ~sensor_polarity_select[gp % 2] : 1'b0;

			always_ff @(posedge clk)
			begin
				if (!nrst)
				begin
					sy1_q[gp]      <= idle;
					sy2_q[gp]      <= idle;
					sy3_q[gp]      <= idle;
					pin_q[gp]      <= idle;
					pin_prev_q[gp] <= idle;
				end
				else
				begin
					sy1_q[gp]      <= pin_raw[gp];
					sy2_q[gp]      <= sy1_q[gp];
					sy3_q[gp]      <= sy2_q[gp];
					pin_prev_q[gp] <= pin_q[gp];
					if (sy2_q[gp] == sy3_q[gp])
						pin_q[gp] <= sy3_q[gp];
				end
			end
		end
	endgenerate

	assign rise = pin_q & ~pin_prev_q;
	assign fall = ~pin_q & pin_prev_q;

	// millisecond and second enables
	logic [$clog2(MS_CYCLES+1)-1:0] div_q;
	logic [9:0]                     sec_div_q;
	logic                           ms_tick;
	logic                           sec_tick;

	assign ms_tick  = (div_q == ($clog2(MS_CYCLES+1))'(MS_CYCLES - 1));
	assign sec_tick = ms_tick && (sec_div_q == 10'(`SBC_SEC_MS - 1));

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			div_q     <= '0;
			sec_div_q <= 10'h000;
		end
		else if (ms_tick)
		begin
			div_q     <= '0;
			sec_div_q <= sec_tick ? 10'h000 : sec_div_q + 10'h001;
		end
		else
			div_q <= div_q + 1'b1;
	end

	// light relays
	logic [1:0]  on_q;
	logic [1:0]  own_q;
	logic [1:0]  ovr_q;
	logic [15:0] tmr_q [2];
	logic [1:0]  motion;
	logic [1:0]  sw_edge;
	logic        grp_sw_evt;
	logic        grp_on;

	assign sw_edge    = rise[1:0];
	assign grp_sw_evt = group_switch_en && sw_edge[group_switch_src];
	assign grp_on     = on_q[0] && on_q[1];
	// contact reads 1 when closed; normally closed sensor signals motion by opening
	assign motion     = (pin_q[3:2] ^ ~sensor_polarity_select) & ~motion_block_bit;

	genvar gl;
	generate
		for (gl = 0; gl < 2; gl++)
		begin : g_light
			logic sw_hit;
			logic sw_tgt;
			logic mot_hit;

			assign sw_hit  = sw_edge[gl] || grp_sw_evt;
			assign sw_tgt  = grp_sw_evt ? ~grp_on : ~on_q[gl];
			assign mot_hit = motion[gl] || (group_sensor_en && motion[group_sensor_src]);

			always_ff @(posedge clk)
			begin
				if (!nrst)
				begin
					on_q[gl]  <= 1'b0;
					own_q[gl] <= 1'b0;
					ovr_q[gl] <= 1'b0;
					tmr_q[gl] <= 16'h0000;
				end
				else if (sw_hit)
				begin
					// edge only: a held switch never dims or repeats
					on_q[gl]  <= sw_tgt;
					ovr_q[gl] <= own_q[gl];
					own_q[gl] <= 1'b0;
					tmr_q[gl] <= 16'h0000;
				end
				else if (mot_hit && !ovr_q[gl] && (!on_q[gl] || own_q[gl]))
				begin
					on_q[gl]  <= 1'b1;
					own_q[gl] <= 1'b1;
					tmr_q[gl] <= motion_off_delay;
				end
				else if (own_q[gl] && sec_tick)
				begin
					if (tmr_q[gl] <= 16'h0001)
					begin
						on_q[gl]  <= 1'b0;
						own_q[gl] <= 1'b0;
					end
					else
						tmr_q[gl] <= tmr_q[gl] - 16'h0001;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			light_relay_one     <= 1'b0;
			light_relay_two     <= 1'b0;
			light_on_state_flag <= 2'b00;
			group_on_state_flag <= 1'b0;
		end
		else
		begin
			light_relay_one     <= on_q[0];
			light_relay_two     <= on_q[1];
			light_on_state_flag <= on_q;
			group_on_state_flag <= grp_on;
		end
	end

	// slat configuration, held here because software may rewrite it
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			slat_step_count <= `SBC_SLAT_STEPS_RST;
			slat_travel_ms  <= `SBC_SLAT_TRAVEL_RST;
		end
		else if (slat_cfg_wr)
		begin
			slat_step_count <= (slat_step_count_wr == 8'h00) ? 8'h01 : slat_step_count_wr;
			slat_travel_ms  <= slat_travel_ms_wr;
		end
	end

	// press timing; index 0 is raise, 1 is lower
	logic [1:0]  bsw;
	logic [1:0]  brise;
	logic [1:0]  bfall;
	logic [11:0] bms_q [2];
	logic [1:0]  ign_q;
	logic [1:0]  rel_short;
	logic [1:0]  rel_full;
	logic [1:0]  hold_evt;
	sbc_state_e  state_q;

	assign bsw   = pin_q[5:4];
	assign brise = rise[5:4];
	assign bfall = fall[5:4];

	genvar gb;
	generate
		for (gb = 0; gb < 2; gb++)
		begin : g_press
			assign rel_short[gb] = bfall[gb] && !ign_q[gb] && (bms_q[gb] < 12'(`SBC_SHORT_MS));
			assign rel_full[gb]  = bfall[gb] && !ign_q[gb] && (bms_q[gb] >= 12'(`SBC_SHORT_MS));
			assign hold_evt[gb]  = bsw[gb] && !ign_q[gb] && ms_tick &&
				(bms_q[gb] == 12'(`SBC_HOLD_MS - 1));

			always_ff @(posedge clk)
			begin
				if (!nrst)
				begin
					bms_q[gb] <= 12'h000;
					ign_q[gb] <= 1'b1;
				end
				else if (brise[gb])
				begin
					bms_q[gb] <= 12'h000;
					// a press that lands while the motor is busy only stops or is dropped
					ign_q[gb] <= (state_q != SBC_IDLE);
				end
				else
				begin
					if (bsw[gb] && ms_tick && bms_q[gb] < 12'(`SBC_HOLD_MS))
						bms_q[gb] <= bms_q[gb] + 12'h001;
					if (hold_evt[gb])
						ign_q[gb] <= 1'b1;
				end
			end
		end
	endgenerate

	// blind motor sequencer
	sbc_kind_e   kind_q;
	sbc_state_e  after_q;
	logic        dir_q;
	logic [19:0] run_ms_q;
	logic [19:0] lim_q;
	logic [6:0]  pos_q;
	logic [7:0]  slat_q;
	logic [15:0] step_ms;
	logic [19:0] full_ms;
	logic [19:0] rest_ms;
	logic [6:0]  moved_pos;
	logic        up;
	logic        any_cmd;

	assign step_ms = slat_travel_ms / 16'(slat_step_count);
	assign full_ms = dir_q ? blind_up_time_ms : blind_down_time_ms;
	// after an upward run slats sit at the top, after a downward run at the bottom
	assign rest_ms = dir_q ? 20'(slat_step_count - slat_q) * 20'(step_ms)
		: 20'(slat_q) * 20'(step_ms);
	assign up      = rel_short[0] || rel_full[0] || hold_evt[0]; // raise wins a tie
	assign any_cmd = up || rel_short[1] || rel_full[1] || hold_evt[1];

	always_comb
	begin
		if (dir_q)
			moved_pos = (7'd100 - pos_q < sbc_pct(run_ms_q, full_ms)) ? `SBC_POS_FULL
				: pos_q + sbc_pct(run_ms_q, full_ms);
		else
			moved_pos = (pos_q < sbc_pct(run_ms_q, full_ms)) ? `SBC_POS_EMPTY
				: pos_q - sbc_pct(run_ms_q, full_ms);
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_q  <= SBC_IDLE;
			after_q  <= SBC_IDLE;
			kind_q   <= SBC_K_STEP;
			dir_q    <= 1'b0;
			run_ms_q <= 20'h00000;
			lim_q    <= 20'h00000;
			pos_q    <= `SBC_POS_EMPTY;
			slat_q   <= 8'h00;
		end
		else
		begin
			case (state_q)
				SBC_IDLE:
				begin
					run_ms_q <= 20'h00000;
					if (any_cmd)
					begin
						dir_q   <= up;
						state_q <= SBC_GAP;
						after_q <= SBC_RUN;
						if (up ? hold_evt[0] : hold_evt[1])
							after_q <= SBC_HOLD;
						else if (up ? rel_full[0] : rel_full[1])
						begin
							kind_q <= SBC_K_FULL;
							lim_q  <= up ? blind_up_time_ms : blind_down_time_ms;
						end
						else if (up ? (slat_q < slat_step_count) : (slat_q != 8'h00))
						begin
							kind_q <= SBC_K_STEP;
							lim_q  <= 20'(step_ms);
						end
						else if (up ? (pos_q != `SBC_POS_FULL) : (pos_q != `SBC_POS_EMPTY))
						begin
							kind_q <= SBC_K_BSTEP;
							lim_q  <= 20'(step_ms);
						end
						else
							state_q <= SBC_IDLE;
					end
				end
				SBC_GAP:
				begin
					// both outputs are off here, so a reversal never overlaps
					if (ms_tick)
						run_ms_q <= run_ms_q + 20'h00001;
					if (run_ms_q >= 20'(`SBC_DEADTIME_MS))
					begin
						state_q  <= after_q;
						run_ms_q <= 20'h00000;
					end
				end
				SBC_RUN:
				begin
					if (ms_tick)
						run_ms_q <= run_ms_q + 20'h00001;
					if ((kind_q == SBC_K_FULL || kind_q == SBC_K_OVR) && (brise != 2'b00))
					begin
						if (kind_q == SBC_K_FULL)
							pos_q <= moved_pos;
						dir_q    <= ~dir_q;
						lim_q    <= rest_ms;
						kind_q   <= SBC_K_REST;
						state_q  <= (rest_ms == 20'h00000) ? SBC_IDLE : SBC_GAP;
						after_q  <= SBC_RUN;
						run_ms_q <= 20'h00000;
					end
					else if (run_ms_q >= lim_q)
					begin
						run_ms_q <= 20'h00000;
						state_q  <= SBC_IDLE;
						case (kind_q)
							SBC_K_STEP:
								slat_q <= dir_q ? slat_q + 8'h01 : slat_q - 8'h01;
							SBC_K_BSTEP:
								pos_q <= moved_pos;
							SBC_K_FULL:
							begin
								pos_q   <= dir_q ? `SBC_POS_FULL : `SBC_POS_EMPTY;
								kind_q  <= SBC_K_OVR;
								lim_q   <= full_ms / 20'(`SBC_OVERRUN_DIV);
								state_q <= SBC_RUN;
							end
							SBC_K_OVR:
							begin
								dir_q   <= ~dir_q;
								lim_q   <= rest_ms;
								kind_q  <= SBC_K_REST;
								state_q <= (rest_ms == 20'h00000) ? SBC_IDLE : SBC_GAP;
								after_q <= SBC_RUN;
							end
							default:
								state_q <= SBC_IDLE;
						endcase
					end
				end
				SBC_HOLD:
				begin
					if (ms_tick)
						run_ms_q <= run_ms_q + 20'h00001;
					// held time counts only from the 2 s crossing onward
					if (!(dir_q ? bsw[0] : bsw[1]))
					begin
						pos_q    <= moved_pos;
						dir_q    <= ~dir_q;
						lim_q    <= rest_ms;
						kind_q   <= SBC_K_REST;
						state_q  <= (rest_ms == 20'h00000) ? SBC_IDLE : SBC_GAP;
						after_q  <= SBC_RUN;
						run_ms_q <= 20'h00000;
					end
				end
				default:
					state_q <= SBC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			raise_motor_output <= 1'b0;
			lower_motor_output <= 1'b0;
			blind_moving       <= 1'b0;
			blind_position     <= `SBC_POS_EMPTY;
			slat_position      <= 8'h00;
		end
		else
		begin
			raise_motor_output <= (state_q == SBC_RUN || state_q == SBC_HOLD) && dir_q;
			lower_motor_output <= (state_q == SBC_RUN || state_q == SBC_HOLD) && !dir_q;
			blind_moving       <= (state_q != SBC_IDLE);
			blind_position     <= pos_q;
			slat_position      <= slat_q;
		end
	end
endmodule

//--- verif/sbc_chk.sv
// Purpose: port level checks of the switch blind control
// Assumes: single clock, synchronous active-low reset
// Notes:   sees a subset of the top ports through bind
`timescale 1ns/1ps
module sbc_chk
#(
	parameter int MS_CYCLES = 25000
)
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        switch_input_one,
	input wire logic        group_switch_en,
	input wire logic        light_relay_one,
	input wire logic        light_relay_two,
	input wire logic [1:0]  light_on_state_flag,
	input wire logic        raise_motor_output,
	input wire logic        lower_motor_output,
	input wire logic        blind_moving,
	input wire logic [6:0]  blind_position,
	input wire logic [7:0]  slat_position,
	input wire logic [7:0]  slat_step_count,
	input wire logic [15:0] slat_travel_ms
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_stop;
		$fell(raise_motor_output) || $fell(lower_motor_output);
	endsequence
	sequence s_dead;
		(!raise_motor_output && !lower_motor_output)[*8];
	endsequence
	sequence s_press;
		$rose(switch_input_one) && !group_switch_en ##1 switch_input_one[*7];
	endsequence
	property p_excl;
		!(raise_motor_output && lower_motor_output);
	endproperty
	a_excl: assert property (p_excl) else $error("both motor outputs on");
	property p_gap;
		s_stop |=> s_dead;
	endproperty
	a_gap: assert property (p_gap) else $error("motor restarted without gap");
	property p_rst;
		disable iff (1'b0) !nrst |=> slat_step_count == 8'h0A && slat_travel_ms == 16'h03E8;
	endproperty
	a_rst: assert property (p_rst) else $error("slat config reset value wrong");
	property p_flag1;
		light_relay_one == light_on_state_flag[0];
	endproperty
	a_flag1: assert property (p_flag1) else $error("relay one and flag differ");
	property p_flag2;
		light_relay_two == light_on_state_flag[1];
	endproperty
	a_flag2: assert property (p_flag2) else $error("relay two and flag differ");
	property p_tog;
		s_press |-> ##[0:3] (light_relay_one != $past(light_relay_one, 10));
	endproperty
	a_tog: assert property (p_tog) else $error("switch edge did not toggle");
	property p_mov;
		$rose(raise_motor_output) || $rose(lower_motor_output) |-> blind_moving;
	endproperty
	a_mov: assert property (p_mov) else $error("motor on while idle");
	property p_slat;
		slat_position <= slat_step_count;
	endproperty
	a_slat: assert property (p_slat) else $error("slat position past range");
	property p_pos;
		blind_position <= 7'h64;
	endproperty
	a_pos: assert property (p_pos) else $error("blind position past full");
endmodule

bind sbc_top sbc_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk, .nrst, .switch_input_one,
	.group_switch_en, .light_relay_one, .light_relay_two, .light_on_state_flag,
	.raise_motor_output, .lower_motor_output, .blind_moving, .blind_position,
	.slat_position, .slat_step_count, .slat_travel_ms);

//--- verif/sbc_far.sv
// Purpose: wall switches and blind motor on the far side
// Assumes: switch contacts read low when open
// Notes:   motor reports only its running time, there is no end stop
`timescale 1ns/1ps
module sbc_far
(
	input  wire logic clk,
	input  wire logic raise_motor_output,
	input  wire logic lower_motor_output,
	output logic      switch_input_one,
	output logic      switch_input_two,
	output logic      raise_switch_input,
	output logic      lower_switch_input,
	output int        run_cyc
);
	int cnt = 0;
	initial
	begin
		switch_input_one = 0;
		switch_input_two = 0;
		raise_switch_input = 0;
		lower_switch_input = 0;
		run_cyc = 0;
	end
	always @(posedge clk)
		if (raise_motor_output || lower_motor_output)
			cnt <= cnt + 1;
		else if (cnt != 0)
		begin
			run_cyc <= cnt;
			cnt <= 0;
		end
	// light switch held long: holding must add nothing
	task automatic tap(input bit two);
		@(negedge clk);
		switch_input_one = !two;
		switch_input_two = two;
		repeat (200) @(negedge clk);
		switch_input_one = 0;
		switch_input_two = 0;
		repeat (40) @(negedge clk);
	endtask
	task automatic press(input bit dn, input int cyc);
		@(negedge clk);
		raise_switch_input = !dn;
		lower_switch_input = dn;
		repeat (cyc) @(negedge clk);
		raise_switch_input = 0;
		lower_switch_input = 0;
	endtask
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench of the switch blind control
// Assumes: 1 ms scaled to 10 clocks, sensors driven here
// Notes:   light states follow an integer model
`timescale 1ns/1ps
module tb;
	import sbc_pkg::*;
	localparam int MS = 10;
	logic        clk = 0;
	logic        nrst = 0;
	logic        sensor_input_one = 1;
	logic        sensor_input_two = 1;
	logic [1:0]  sensor_polarity_select = 0;
	logic [1:0]  motion_block_bit = 0;
	logic [15:0] motion_off_delay = 16'h0001;
	logic        group_sensor_en = 0;
	logic        group_sensor_src = 0;
	logic        group_switch_en = 0;
	logic        group_switch_src = 0;
	logic        slat_cfg_wr = 0;
	logic [7:0]  slat_step_count_wr = 8'h05;
	logic [15:0] slat_travel_ms_wr = 16'h01F4;
	logic [19:0] blind_up_time_ms = 20'h00064;
	logic [19:0] blind_down_time_ms = 20'h000C8;
	logic        switch_input_one, switch_input_two, raise_switch_input, lower_switch_input;
	logic        light_relay_one, light_relay_two, group_on_state_flag;
	logic        raise_motor_output, lower_motor_output, blind_moving;
	logic [1:0]  light_on_state_flag;
	logic [6:0]  blind_position;
	logic [7:0]  slat_position, slat_step_count;
	logic [15:0] slat_travel_ms;
	int          run_cyc, n, k;
	int          err_count = 0;
	int          checked = 0;
	int          exp_l[2] = '{0, 0};
	always #20 clk = ~clk;
	sbc_top #(.MS_CYCLES(MS)) dut (.clk, .nrst, .switch_input_one, .switch_input_two,
		.sensor_input_one, .sensor_input_two, .raise_switch_input, .lower_switch_input,
		.sensor_polarity_select, .motion_block_bit, .motion_off_delay, .group_sensor_en,
		.group_sensor_src, .group_switch_en, .group_switch_src, .slat_cfg_wr,
		.slat_step_count_wr, .slat_travel_ms_wr, .blind_up_time_ms, .blind_down_time_ms,
		.light_relay_one, .light_relay_two, .light_on_state_flag, .group_on_state_flag,
		.raise_motor_output, .lower_motor_output, .blind_moving, .blind_position,
		.slat_position, .slat_step_count, .slat_travel_ms);
	sbc_far p (.clk, .raise_motor_output, .lower_motor_output, .switch_input_one,
		.switch_input_two, .raise_switch_input, .lower_switch_input, .run_cyc);
	task automatic chk(input logic [15:0] a, input logic [15:0] e);
		checked++;
		if (a !== e)
		begin
			err_count++;
			$display("MISMATCH t=%0t got %0h exp %0h", $time, a, e);
		end
	endtask
	// durations get a few clocks of slack for sync latency
	task automatic chk_t(input int a, input int e);
		checked++;
		if (a < e - 3 || a > e + 3)
		begin
			err_count++;
			$display("MISMATCH t=%0t took %0d exp %0d", $time, a, e);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wt(ref logic s, input logic v, input int lim);
		n = 0;
		while (s !== v && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		if (s !== v)
		begin
			err_count++;
			$display("MISMATCH t=%0t wait ran out", $time);
			finish_test();
		end
	endtask
	task automatic lights();
		repeat (20) @(negedge clk);
		chk(light_relay_one, exp_l[0][0]);
		chk(light_relay_two, exp_l[1][0]);
	endtask
	task automatic blind(input bit dn, input int cyc);
		wt(blind_moving, 1'b0, 3000 * MS);
		p.press(dn, cyc);
	endtask
	initial
	begin
		void'($urandom(32'h42B4E15F));
		repeat (5) @(negedge clk);
		nrst = 1;
		@(negedge clk);
		chk(slat_step_count, 8'h0A);
		chk(slat_travel_ms, 16'h03E8);
		$display("test reset done");
		repeat (10) @(negedge clk);
		p.tap(0);
		exp_l[0] = 1;
		lights();
		p.tap(0);
		exp_l[0] = 0;
		lights();
		p.tap(1);
		exp_l[1] = 1;
		lights();
		group_switch_en = 1;
		p.tap(0);
		exp_l = '{1, 1};
		lights();
		chk(group_on_state_flag, 1'b1);
		group_switch_src = 1;
		p.tap(1);
		exp_l = '{0, 0};
		lights();
		p.tap(1);
		exp_l = '{1, 1};
		lights();
		group_switch_en = 0;
		p.tap(0);
		p.tap(1);
		exp_l = '{0, 0};
		lights();
		$display("test switch done");
		sensor_input_one = 0;
		exp_l[0] = 1;
		lights();
		sensor_input_one = 1;
		wt(light_relay_one, 1'b0, 2200 * MS);
		sensor_input_one = 0;
		sensor_polarity_select = 2'h1;
		@(negedge clk);
		sensor_input_one = 1;
		lights();
		p.tap(0);
		exp_l[0] = 0;
		lights();
		repeat (300) @(negedge clk);
		lights();
		p.tap(0);
		exp_l[0] = 1;
		lights();
		sensor_input_one = 0;
		p.tap(0);
		exp_l[0] = 0;
		motion_block_bit = 2'h2;
		sensor_input_two = 0;
		repeat (300) @(negedge clk);
		lights();
		motion_block_bit = 2'h0;
		exp_l[1] = 1;
		lights();
		sensor_input_two = 1;
		motion_off_delay = 16'h0002;
		group_sensor_en = 1;
		group_sensor_src = 1;
		sensor_input_two = 0;
		exp_l = '{1, 1};
		lights();
		sensor_input_two = 1;
		group_sensor_en = 0;
		$display("test motion done");
		k = 500 + int'($urandom % 2500);
		blind(0, k);
		wt(raise_motor_output, 1'b1, 300 * MS);
		wt(raise_motor_output, 1'b0, 200 * MS);
		@(negedge clk);
		chk_t(run_cyc, 100 * MS);
		chk(slat_position, 16'h0001);
		blind(0, 500 * MS);
		wt(raise_motor_output, 1'b1, 300 * MS);
		wt(raise_motor_output, 1'b0, 1200 * MS);
		@(negedge clk);
		chk_t(run_cyc, 105 * MS);
		chk(blind_position, 7'h64);
		blind(1, 500 * MS);
		wt(lower_motor_output, 1'b1, 300 * MS);
		wt(lower_motor_output, 1'b0, 2200 * MS);
		@(negedge clk);
		chk_t(run_cyc, 210 * MS);
		chk(blind_position, 7'h00);
		blind_up_time_ms = 20'h003E8;
		blind(0, 2500 * MS);
		repeat (10) @(negedge clk);
		chk(raise_motor_output, 1'b0);
		chk_t(int'(blind_position), 50);
		blind(1, 500 * MS);
		wt(lower_motor_output, 1'b1, 300 * MS);
		fork
			p.press(0, 100 * MS);
		join_none
		repeat (20) @(negedge clk);
		chk(lower_motor_output | raise_motor_output, 1'b0);
		wait fork;
		wt(blind_moving, 1'b0, 3000 * MS);
		slat_step_count_wr = 8'(1 + $urandom % 15);
		slat_cfg_wr = 1;
		@(negedge clk);
		slat_cfg_wr = 0;
		@(negedge clk);
		chk(slat_step_count, 16'(slat_step_count_wr));
		chk(slat_travel_ms, 16'h01F4);
		$display("test blind done");
		finish_test();
	end
endmodule
